// *** design/tcp_top.sv ***
// tcp_top: trace gating, trace collector registers, triggers and packing
// assumes the pipeline holds its trace inputs while pipe_stall is high
//
// Contract
// - nothing but trigger info bytes traced unless trace-on is set
// - trace only instructions in enabled processor modes
// - breakpoint forces all modes on; another cancels
// - mode traced on first and sync instructions
// - mode change traced if old or new enabled
// - eight selectable address and data content sets
// - user data write while on gives record
// - user data traced even in untraced modes
// - pieces forwarded to sinks only while enabled
// - transmit enable set by tap and triggers
// - zero to eight triggers, only those exist
// - trigger fires on probe, chip, debug entry
// - trigger actions: outputs, enable, info byte
// - triggers never touch breakpoint trace control
// - pack trace losslessly into 64-bit words
// - optional cycle timing; else completions only
// - six trace formats, each with nonzero bit
// - empty trace word is all zeros
// - used word has nonzero low nibble
// - full word goes to memory or probe
// - control a, b, data by tap; select
// - pointer registers only with on-chip memory
// - source select picks software or tap control
`timescale 1ns/1ns
module tcp_top #(
  parameter int NTRIG = 8,
  parameter int MEM_EN = 1,
  parameter int MEM_AW = 6,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pipe_valid,
  input wire logic [1:0] pipe_mode,
  input wire logic pipe_sync,
  input wire logic [31:0] pipe_pc,
  input wire logic pipe_is_ld,
  input wire logic pipe_is_st,
  input wire logic [31:0] pipe_addr,
  input wire logic [31:0] pipe_data,
  input wire logic user_data_wr,
  input wire logic [31:0] user_data,
  input wire logic sw_trace_on,
  input wire logic [3:0] sw_mode_en,
  input wire logic [2:0] sw_info_sel,
  input wire logic trace_source_select,
  input wire logic bkpt_trace_on,
  input wire logic bkpt_trace_off,
  input wire logic probe_trig_in,
  input wire logic chip_trig_in,
  input wire logic [7:0] tap_ir,
  input wire logic tap_wr,
  input wire logic tap_rd,
  input wire logic [31:0] tap_wdata,
  output logic [31:0] tap_rdata,
  input wire logic probe_ready,
  output logic probe_valid,
  output logic [2*tcp_pkg::PIECE_W-13:0] probe_data,
  output logic probe_trig_out,
  output logic chip_trig_out,
  output logic pipe_stall
);
  import tcp_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
    logic [7:0][15:0] trig;
    logic [MEM_AW:0] rdp;
    logic [MEM_AW-1:0] wrp;
    logic [MEM_AW-1:0] stp;
    logic force_all;
    logic first;
    logic [1:0] prev_mode;
    logic [2:0] prev_in;
    tcp_cd_e cd;
    logic [7:0] cd_cnt;
    logic [4:0] pmask;
    logic [3:0] p_fmt;
    logic [1:0] p_mode;
    logic p_ld;
    logic p_st;
    logic [31:0] p_pc;
    logic [31:0] p_addr;
    logic [31:0] p_data;
    logic [31:0] p_user;
    logic [7:0] p_info;
    logic [63:0] cur;
    logic [6:0] fill;
    logic wvalid;
    logic [63:0] word;
    logic pv;
    logic [63:0] pdata;
    logic ptrig;
    logic ctrig;
    logic stall;
    logic [31:0] rdata;
  } tcp_top_s;

  tcp_top_s st, next_st;
  logic on, en, traced, chg, need_mode, take_piece, blocked, pc_v;
  logic fire, en_act, fire_prb;
  logic [3:0] menb, infl;
  logic [2:0] isel, rise;
  logic [4:0] sel, pc_clr;
  logic [PIECE_W-1:0] pc_bits;
  logic [6:0] pc_len, sum;
  logic [31:0] rd_mux;
  logic trig_hit;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, mem_we;
  logic [63:0] fifo_out_data, mem_rdata;

  assign tap_rdata = st.rdata;
  assign probe_valid = st.pv;
  assign probe_data = st.pdata;
  assign probe_trig_out = st.ptrig;
  assign chip_trig_out = st.ctrig;
  assign pipe_stall = st.stall;

  // offered word leaves towards the probe or the memory
  assign fifo_out_ready = st.ctrl_b[CB_OFC] ? (!st.pv || probe_ready) : 1'b1;
  assign mem_we = fifo_out_valid && !st.ctrl_b[CB_OFC] && (MEM_EN != 0);

  tcp_fifo #(.W(64), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(st.wvalid),
    .in_ready(fifo_in_ready),
    .in_data(st.word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  tcp_tmem #(.W(64), .AW(MEM_AW)) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .we(mem_we),
    .waddr(st.wrp),
    .wdata(fifo_out_data),
    .raddr(st.rdp[MEM_AW:1]),
    .rdata(mem_rdata)
  );

  // register read mux for the tap data path
  always_comb begin
    sel = st.ctrl_b[CB_REG_LO +: 5];
    trig_hit = sel[4:3] == SEL_TRIG_HI && int'(sel[2:0]) < NTRIG;
    rd_mux = '0;
    if (tap_ir == IR_CTRL_A) begin
      rd_mux = (st.ctrl_a & CA_WMASK) | CA_VMODES;
    end else if (tap_ir == IR_CTRL_B) begin
      rd_mux = st.ctrl_b;
    end else if (tap_ir == IR_DATA) begin
      if (sel == SEL_CONFIG) begin
        rd_mux = (32'(NTRIG) << CFG_TRIG_LO) | (32'(MEM_EN != 0) << CFG_MEM);
      end else if (MEM_EN == 0) begin
        rd_mux = '0;
      end else if (sel == SEL_TW) begin
        rd_mux = st.rdp[0] ? mem_rdata[63:32] : mem_rdata[31:0];
      end else if (sel == SEL_RDP) begin
        rd_mux = 32'(st.rdp);
      end else if (sel == SEL_WRP) begin
        rd_mux = 32'(st.wrp);
      end else if (sel == SEL_STP) begin
        rd_mux = 32'(st.stp);
      end else if (trig_hit) begin
        rd_mux = 32'(st.trig[sel[2:0]]);
      end
    end
  end

  // pick the lowest pending piece and shape it as a trace format
  always_comb begin
    pc_v = 1'b1;
    pc_bits = '0;
    pc_len = '0;
    pc_clr = '0;
    if (st.pmask[P_INSN]) begin
      pc_clr[P_INSN] = 1'b1;
      if (st.p_fmt == TF_MODE) begin
        pc_bits = {st.p_pc, st.p_mode, TF_MODE};
        pc_len = LEN_MODE;
      end else if (st.p_fmt == TF_INSN) begin
        pc_bits = PIECE_W'({st.p_st, st.p_ld, TF_INSN});
        pc_len = LEN_INSN;
      end else begin
        pc_bits = PIECE_W'(TF_IDLE);
        pc_len = LEN_IDLE;
      end
    end else if (st.pmask[P_ADDR]) begin
      pc_clr[P_ADDR] = 1'b1;
      pc_bits = PIECE_W'({st.p_addr, st.p_st, TF_ADDR});
      pc_len = LEN_WORD;
    end else if (st.pmask[P_DATA]) begin
      pc_clr[P_DATA] = 1'b1;
      pc_bits = PIECE_W'({st.p_data, st.p_st, TF_DATA});
      pc_len = LEN_WORD;
    end else if (st.pmask[P_USER]) begin
      pc_clr[P_USER] = 1'b1;
      pc_bits = PIECE_W'({st.p_user, 1'b0, TF_USER});
      pc_len = LEN_WORD;
    end else if (st.pmask[P_INFO]) begin
      pc_clr[P_INFO] = 1'b1;
      pc_bits = PIECE_W'({st.p_info, 1'b1, TF_USER});
      pc_len = LEN_WORD;
    end else begin
      pc_v = 1'b0;
    end
  end

  // main next-state logic
  always_comb begin
    next_st = st;
    next_st.ptrig = 1'b0;
    next_st.ctrig = 1'b0;
    // software or tap control of trace modes
    on = trace_source_select ? st.ctrl_a[CA_ON] : sw_trace_on;
    menb = trace_source_select ? {st.ctrl_a[CA_D], st.ctrl_a[CA_E],
                                  st.ctrl_a[CA_K], st.ctrl_a[CA_U]}
                               : sw_mode_en;
    isel = trace_source_select ? st.ctrl_a[CA_INFO_LO +: 3] : sw_info_sel;
    infl = tcp_info_flags(isel);
    en = st.ctrl_b[CB_EN];
    traced = 1'b0;
    chg = 1'b0;
    need_mode = 1'b0;
    fire = 1'b0;
    en_act = 1'b0;
    fire_prb = 1'b0;
    sum = 7'(st.fill + pc_len);
    rise = {pipe_mode == MODE_DEBUG, chip_trig_in, probe_trig_in} & ~st.prev_in;
    next_st.prev_in = {pipe_mode == MODE_DEBUG, chip_trig_in, probe_trig_in};

    // a word waiting on a full fifo holds the whole packer back
    blocked = st.wvalid && !fifo_in_ready;
    take_piece = pc_v && !blocked;
    if (st.wvalid && fifo_in_ready) begin
      next_st.wvalid = 1'b0;
    end
    if (take_piece) begin
      next_st.pmask = st.pmask & ~pc_clr;
    end
    // disabled transmit drops pieces; the pipeline side keeps flowing
    if (take_piece && en) begin
      if (sum > TW_W) begin
        next_st.wvalid = 1'b1;
        next_st.word = st.cur;
        next_st.cur = 64'(pc_bits);
        next_st.fill = pc_len;
      end else begin
        next_st.cur = st.cur | (64'(pc_bits) << st.fill);
        next_st.fill = sum;
        if (sum == TW_W) begin
          next_st.wvalid = 1'b1;
          next_st.word = next_st.cur;
          next_st.cur = '0;
          next_st.fill = '0;
        end
      end
    end

    // pipeline sampling; accepted only when nothing is pending
    if (!st.stall) begin
      if (pipe_valid) begin
        traced = on && (menb[pipe_mode] || st.force_all);
        chg = on && pipe_mode != st.prev_mode &&
              (menb[st.prev_mode] || menb[pipe_mode]);
        need_mode = (traced && (st.first || pipe_sync)) || chg;
        next_st.prev_mode = pipe_mode;
        if (traced || need_mode) begin
          next_st.pmask[P_INSN] = 1'b1;
          next_st.p_fmt = need_mode ? TF_MODE : TF_INSN;
          next_st.p_pc = pipe_pc;
          next_st.p_mode = pipe_mode;
          next_st.p_ld = pipe_is_ld;
          next_st.p_st = pipe_is_st;
        end
        if (traced) begin
          next_st.first = 1'b0;
          next_st.p_addr = pipe_addr;
          next_st.p_data = pipe_data;
          next_st.pmask[P_ADDR] = (pipe_is_ld && infl[0]) ||
                                  (pipe_is_st && infl[1]);
          next_st.pmask[P_DATA] = (pipe_is_ld && infl[2]) ||
                                  (pipe_is_st && infl[3]);
        end
      end else if (on && st.ctrl_b[CB_CYC]) begin
        next_st.pmask[P_INSN] = 1'b1;
        next_st.p_fmt = TF_IDLE;
      end
      // user records ignore the mode enables
      if (user_data_wr && on) begin
        next_st.pmask[P_USER] = 1'b1;
        next_st.p_user = user_data;
      end
    end
    if (!on) begin
      next_st.first = 1'b1;
    end

    // breakpoint override; a start on the same cycle as a stop wins
    if (bkpt_trace_off) begin
      next_st.force_all = 1'b0;
    end
    if (bkpt_trace_on) begin
      next_st.force_all = 1'b1;
    end

    // countdown to clear transmit enable
    if (st.cd == CD_RUN) begin
      if (st.cd_cnt == '0) begin
        next_st.ctrl_b[CB_EN] = 1'b0;
        next_st.cd = CD_IDLE;
      end else begin
        next_st.cd_cnt = 8'(st.cd_cnt - 1'b1);
      end
    end

    // tap writes; trigger actions below take priority on the enable bit
    if (tap_wr) begin
      if (tap_ir == IR_CTRL_A) begin
        next_st.ctrl_a = (tap_wdata & CA_WMASK) | (st.ctrl_a & ~CA_WMASK);
      end else if (tap_ir == IR_CTRL_B) begin
        next_st.ctrl_b = (tap_wdata & CB_WMASK) | (next_st.ctrl_b & ~CB_WMASK);
      end else if (tap_ir == IR_DATA) begin
        if (MEM_EN == 0) begin
          next_st.rdp = st.rdp;
        end else if (sel == SEL_RDP) begin
          next_st.rdp = tap_wdata[MEM_AW:0];
        end else if (sel == SEL_WRP) begin
          next_st.wrp = tap_wdata[MEM_AW-1:0];
        end else if (sel == SEL_STP) begin
          next_st.stp = tap_wdata[MEM_AW-1:0];
        end
        if (trig_hit) begin
          next_st.trig[sel[2:0]] = tap_wdata[15:0];
        end
      end
    end
    if (tap_rd) begin
      next_st.rdata = rd_mux;
      if (tap_ir == IR_DATA && sel == SEL_TW && MEM_EN != 0) begin
        next_st.rdp = (MEM_AW+1)'(st.rdp + 1'b1);
      end
    end

    // triggers act on the enable, the pins and the info slot only
    for (int i = 0; i < 8; i++) begin
      if (i < NTRIG) begin
        fire = |(st.trig[i][TG_SRC_LO +: 3] & rise);
        if (fire) begin
          next_st.ptrig = next_st.ptrig | st.trig[i][TG_ACT_PRB];
          next_st.ctrig = next_st.ctrig | st.trig[i][TG_ACT_CHP];
          fire_prb = fire_prb | st.trig[i][TG_ACT_PRB];
          if (st.trig[i][TG_EN_LO +: 2] == EN_SET) begin
            next_st.ctrl_b[CB_EN] = 1'b1;
            next_st.cd = CD_IDLE;
            en_act = 1'b1;
          end else if (st.trig[i][TG_EN_LO +: 2] == EN_CLR) begin
            next_st.ctrl_b[CB_EN] = 1'b0;
            next_st.cd = CD_IDLE;
            en_act = 1'b1;
          end else if (st.trig[i][TG_EN_LO +: 2] == EN_CD) begin
            next_st.cd = CD_RUN;
            next_st.cd_cnt = 8'(CD_CYCLES - 1'b1);
            en_act = 1'b1;
          end
          if (st.trig[i][TG_INFO_EN]) begin
            next_st.pmask[P_INFO] = 1'b1;
            next_st.p_info = st.trig[i][TG_BYTE_LO +: 8];
          end
        end
      end
    end

    // drain the fifo into the probe register or the memory
    if (st.pv && probe_ready) begin
      next_st.pv = 1'b0;
    end
    if (fifo_out_valid && fifo_out_ready) begin
      if (st.ctrl_b[CB_OFC]) begin
        next_st.pv = 1'b1;
        next_st.pdata = fifo_out_data;
      end else if (MEM_EN != 0) begin
        next_st.wrp = MEM_AW'(st.wrp + 1'b1);
      end
    end
    next_st.stall = |next_st.pmask;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl_a <= CA_RESET;
      st.ctrl_b <= CB_RESET;
      st.first <= 1'b1;
      st.cd <= CD_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // checks on the gating, packing and enable paths
  localparam int CD_LO = 1;
  localparam int CD_HI = 40;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_en_write;
    tap_wr && tap_ir == IR_CTRL_B && !en_act && st.cd == CD_IDLE;
  endsequence
  sequence s_cd_start;
    st.cd == CD_IDLE ##1 st.cd == CD_RUN && !en_act;
  endsequence

  property p_off_quiet;
    !st.stall && !on |=> !st.pmask[P_INSN];
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("insn while off");
  property p_mode_gate;
    !st.stall && pipe_valid && on && !menb[pipe_mode] && !st.force_all &&
      pipe_mode == st.prev_mode |=> !st.pmask[P_INSN];
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("mode leak");
  property p_force;
    bkpt_trace_on |=> st.force_all;
  endproperty
  a_force: assert property (p_force) else $error("no force");
  property p_user;
    !st.stall && user_data_wr && on |=>
      st.pmask[P_USER] && st.p_user == $past(user_data);
  endproperty
  a_user: assert property (p_user) else $error("user record lost");
  property p_drop;
    take_piece && !en |=> st.fill == $past(st.fill);
  endproperty
  a_drop: assert property (p_drop) else $error("packed while off");
  property p_tap_en;
    s_en_write |=> st.ctrl_b[CB_EN] == $past(tap_wdata[CB_EN]);
  endproperty
  a_tap_en: assert property (p_tap_en) else $error("tap enable");
  property p_cd;
    s_cd_start |-> ##[CD_LO:CD_HI] !st.ctrl_b[CB_EN];
  endproperty
  a_cd: assert property (p_cd) else $error("countdown stuck");
  property p_trig_out;
    fire_prb |=> probe_trig_out;
  endproperty
  a_trig_out: assert property (p_trig_out) else $error("no trig out");
  property p_empty;
    st.fill == '0 |-> st.cur == '0;
  endproperty
  a_empty: assert property (p_empty) else $error("empty not zero");
  property p_nibble;
    probe_valid |-> probe_data[3:0] != '0;
  endproperty
  a_nibble: assert property (p_nibble) else $error("low nibble zero");
  property p_fill;
    st.fill < TW_W;
  endproperty
  a_fill: assert property (p_fill) else $error("fill overrun");
endmodule : tcp_top

// *** design/tcp_pkg.sv ***
// tcp_pkg: constants and types shared by the trace control and packing block
// assumes a single clock domain; the tap side presents decoded instructions
package tcp_pkg;

  // tap instruction codes reaching the collector registers
  localparam logic [7:0] IR_CTRL_A = 8'h10;
  localparam logic [7:0] IR_CTRL_B = 8'h11;
  localparam logic [7:0] IR_DATA = 8'h12;

  // register_select_field values seen through trace_data_port
  localparam logic [4:0] SEL_CONFIG = 5'h00;
  localparam logic [4:0] SEL_TW = 5'h04;
  localparam logic [4:0] SEL_RDP = 5'h05;
  localparam logic [4:0] SEL_WRP = 5'h06;
  localparam logic [4:0] SEL_STP = 5'h07;
  localparam logic [1:0] SEL_TRIG_HI = 2'h2;

  // trace_ctrl_a fields
  localparam int CA_ON = 0;
  localparam int CA_INFO_LO = 1;
  localparam int CA_U = 13;
  localparam int CA_K = 14;
  localparam int CA_E = 16;
  localparam int CA_D = 17;
  localparam logic [31:0] CA_WMASK = 32'h007F7FFF;
  localparam logic [31:0] CA_RESET = 32'h00400000;
  localparam logic [31:0] CA_VMODES = 32'h02000000;

  // trace_ctrl_b fields
  localparam int CB_EN = 0;
  localparam int CB_CYC = 1;
  localparam int CB_OFC = 2;
  localparam int CB_REG_LO = 20;
  localparam logic [31:0] CB_WMASK = 32'h01F00007;
  localparam logic [31:0] CB_RESET = 32'h00000000;

  // trace_block_config fields
  localparam int CFG_MEM = 0;
  localparam int CFG_TRIG_LO = 8;

  // trace_trigger_n fields
  localparam int TG_SRC_LO = 0;
  localparam int TG_ACT_PRB = 3;
  localparam int TG_ACT_CHP = 4;
  localparam int TG_EN_LO = 5;
  localparam int TG_INFO_EN = 7;
  localparam int TG_BYTE_LO = 8;
  localparam logic [1:0] EN_SET = 2'h1;
  localparam logic [1:0] EN_CLR = 2'h2;
  localparam logic [1:0] EN_CD = 2'h3;
  localparam logic [7:0] CD_CYCLES = 8'h20;

  // processor modes and trace format headers
  localparam logic [1:0] MODE_DEBUG = 2'h3;
  localparam logic [3:0] TF_IDLE = 4'h1;
  localparam logic [3:0] TF_INSN = 4'h2;
  localparam logic [3:0] TF_MODE = 4'h3;
  localparam logic [3:0] TF_ADDR = 4'h4;
  localparam logic [3:0] TF_DATA = 4'h5;
  localparam logic [3:0] TF_USER = 4'h6;
  localparam logic [6:0] LEN_IDLE = 7'h04;
  localparam logic [6:0] LEN_INSN = 7'h06;
  localparam logic [6:0] LEN_MODE = 7'h26;
  localparam logic [6:0] LEN_WORD = 7'h25;
  localparam logic [6:0] TW_W = 7'h40;
  localparam int PIECE_W = 38;

  // pending piece slots, lowest drains first
  localparam int P_INSN = 0;
  localparam int P_ADDR = 1;
  localparam int P_DATA = 2;
  localparam int P_USER = 3;
  localparam int P_INFO = 4;

  typedef enum logic {CD_IDLE, CD_RUN} tcp_cd_e;

  // info select to {store data, load data, store addr, load addr}
  function automatic logic [3:0] tcp_info_flags(input logic [2:0] sel);
    case (sel)
      3'h1: tcp_info_flags = 4'h1;
      3'h2: tcp_info_flags = 4'h2;
      3'h3: tcp_info_flags = 4'h3;
      3'h4: tcp_info_flags = 4'h5;
      3'h5: tcp_info_flags = 4'hA;
      3'h6: tcp_info_flags = 4'hF;
      3'h7: tcp_info_flags = 4'h4;
      default: tcp_info_flags = 4'h0;
    endcase
  endfunction : tcp_info_flags

endpackage : tcp_pkg

// *** design/tcp_fifo.sv ***
// tcp_fifo: word fifo between the packer and the trace sinks
// assumes DEPTH is a power of two so the pointers wrap by themselves
`timescale 1ns/1ns
module tcp_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } tcp_fifo_s;
  tcp_fifo_s st, next_st;
  logic push, pop;

  // full and empty come straight from the count
  assign in_ready = st.cnt != (AW+1)'(DEPTH);
  assign out_valid = st.cnt != '0;
  assign out_data = st.mem[st.rd];

  always_comb begin
    next_st = st;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = AW'(st.wr + 1'b1);
    end
    if (pop) begin
      next_st.rd = AW'(st.rd + 1'b1);
    end
    if (push && !pop) begin
      next_st.cnt = (AW+1)'(st.cnt + 1'b1);
    end else if (pop && !push) begin
      next_st.cnt = (AW+1)'(st.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : tcp_fifo

// *** design/tcp_tmem.sv ***
// tcp_tmem: on-chip trace memory, one write port, registered read data
// assumes the caller keeps the read address steady for a cycle before use
`timescale 1ns/1ns
module tcp_tmem #(
  parameter int W = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  typedef struct packed {
    logic [(2**AW)-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } tcp_tmem_s;
  tcp_tmem_s st, next_st;

  assign rdata = st.rdata;

  // read sees the old word on a same-address write
  always_comb begin
    next_st = st;
    next_st.rdata = st.mem[raddr];
    if (we) begin
      next_st.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : tcp_tmem

// *** verification/tcp_probe_sink.sv ***
// tcp_probe_sink: probe-side sink that takes packed trace words
// assumes a word is taken on the rising edge where valid and ready meet
`timescale 1ns/1ns
module tcp_probe_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic valid,
  input wire logic [63:0] data,
  output logic ready,
  output logic [63:0] last,
  output int unsigned cnt
);
  // ready is registered, so a hold request stops the sink taking words a cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'h0;
      cnt <= 0;
      last <= 64'h0;
    end else begin
      ready <= !hold;
      if (valid && ready) begin
        last <= data;
        cnt <= cnt + 1;
      end
    end
  end
endmodule : tcp_probe_sink

// *** verification/tb_tcp_top.sv ***
// tb_tcp_top: tap register and pipeline sequences with expected values
// assumes two triggers, on-chip memory and the probe sink model
`timescale 1ns/1ns
module tb_tcp_top;
  import tcp_pkg::*;
  logic clk = 0, rst_n = 0, pv = 0, sy = 0, ld = 0, uw = 0, on = 0;
  logic bon = 0, boff = 0, pti = 0, cti = 0, twr = 0, trd = 0, hold = 1;
  logic [3:0] men = 0;
  logic [1:0] md = 0;
  logic tss = 0;
  logic [7:0] ir = 0;
  logic [31:0] pc = 0, wd = 0, rdat;
  logic pvld, prdy, pto, cto, stall;
  logic [63:0] pdat, last;
  int unsigned cnt;
  int error_cnt = 0, n_checks = 0;

  // free-running 25 MHz clock
  always #20 clk = ~clk;

  tcp_top #(.NTRIG(2)) i_tcp_top (.clk(clk), .rst_n(rst_n),
    .pipe_valid(pv), .pipe_mode(md), .pipe_sync(sy), .pipe_pc(pc),
    .pipe_is_ld(ld), .pipe_is_st(1'h0), .pipe_addr(pc), .pipe_data(~pc),
    .user_data_wr(uw), .user_data(pc), .sw_trace_on(on), .sw_mode_en(men),
    .sw_info_sel(3'h0), .trace_source_select(tss), .bkpt_trace_on(bon),
    .bkpt_trace_off(boff), .probe_trig_in(pti), .chip_trig_in(cti),
    .tap_ir(ir), .tap_wr(twr), .tap_rd(trd), .tap_wdata(wd),
    .tap_rdata(rdat), .probe_ready(prdy), .probe_valid(pvld),
    .probe_data(pdat), .probe_trig_out(pto), .chip_trig_out(cto),
    .pipe_stall(stall));

  tcp_probe_sink i_tcp_probe_sink (.clk(clk), .rst_n(rst_n), .hold(hold),
    .valid(pvld), .data(pdat), .ready(prdy), .last(last), .cnt(cnt));

  // inputs move 2 ns after the edge so sampling never races
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  task automatic chk(logic [63:0] got, logic [63:0] exp, string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // one tap cycle; read data is taken a cycle after the capture edge
  task automatic tap(logic [7:0] r, logic [31:0] d, logic w);
    ir = r;
    wd = d;
    twr = w;
    trd = !w;
    step(1);
    twr = 0;
    trd = 0;
    step(1);
  endtask : tap

  // inputs are held while stalled, as the pipeline must
  task automatic ins(logic v, logic u, logic exp, string m);
    int k;
    k = 0;
    pv = v;
    uw = u;
    step(1);
    chk(stall, exp, m);
    while (stall && k < 40) begin
      step(1);
      k++;
    end
    pv = 0;
    uw = 0;
    pc = pc + 4;
    // a stall that never drains is a failure, not a quiet end
    if (k >= 40) begin
      chk(stall, 1'h0, m);
      conclude();
    end
    step(1);
  endtask : ins

  // main sequence: registers, triggers, gating, packing
  initial begin
    int k;
    step(10);
    rst_n = 1;
    step(1);
    tap(IR_CTRL_A, 32'h0, 1'h0);
    chk(rdat, 32'h02400000, "ctrl_a reset");
    tap(IR_DATA, 32'h0, 1'h0);
    chk({rdat[11:8], rdat[0]}, 5'h05, "config");
    tap(IR_CTRL_B, 32'h01300000, 1'h1);
    tap(IR_DATA, 32'h000000FF, 1'h1);
    tap(IR_DATA, 32'h0, 1'h0);
    chk(rdat, 32'h0, "absent trigger");
    tap(IR_CTRL_B, 32'h01000005, 1'h1);
    tap(IR_DATA, 32'h00000049, 1'h1);
    tap(IR_CTRL_B, 32'h0, 1'h0);
    chk(rdat, 32'h01000005, "enable by tap");
    $display("test registers done");
    pti = 1;
    cti = 1;
    k = 0;
    while (!pto && k < 4) begin
      step(1);
      k++;
    end
    chk(pto, 1'h1, "probe trigger out");
    chk(cto, 1'h0, "chip trigger out");
    pti = 0;
    cti = 0;
    tap(IR_CTRL_B, 32'h0, 1'h0);
    chk(rdat, 32'h01000004, "enable cleared");
    $display("test trigger done");
    men = 4'hF;
    ins(1'h1, 1'h0, 1'h0, "trace off");
    on = 1;
    men = 4'h2;
    ins(1'h1, 1'h0, 1'h0, "masked mode");
    ins(1'h0, 1'h1, 1'h1, "user data");
    bon = 1;
    step(1);
    bon = 0;
    ins(1'h1, 1'h0, 1'h1, "override on");
    boff = 1;
    step(1);
    boff = 0;
    ins(1'h1, 1'h0, 1'h0, "override off");
    $display("test gating done");
    tap(IR_CTRL_B, 32'h00000005, 1'h1);
    men = 4'h1;
    sy = 1;
    ld = 1;
    pc = 32'h00001000;
    ins(1'h1, 1'h0, 1'h1, "sync");
    sy = 0;
    repeat (6) ins(1'h1, 1'h0, 1'h1, "insn");
    hold = 0;
    k = 0;
    while (cnt == 0 && k < 50) begin
      step(1);
      k++;
    end
    chk(last, {2'h0, {4{1'b0, 1'b1, TF_INSN}}, 32'h00001000, 2'h0, TF_MODE},
        "word");
    $display("test packing done");
    // tap-side control with its on bit clear silences the software enables
    tss = 1;
    ins(1'h1, 1'h0, 1'h0, "tap control off");
    tss = 0;
    md = 2'h1;
    ins(1'h1, 1'h0, 1'h1, "leave enabled mode");
    ins(1'h1, 1'h0, 1'h0, "stay masked mode");
    md = 2'h2;
    ins(1'h1, 1'h0, 1'h0, "masked to masked");
    // trigger 1: chip or debug entry, chip out, countdown on the enable
    tap(IR_CTRL_B, 32'h01100005, 1'h1);
    tap(IR_DATA, 32'h00000076, 1'h1);
    md = 2'h3;
    step(1);
    chk(cto, 1'h1, "debug entry");
    step(20);
    tap(IR_CTRL_B, 32'h0, 1'h0);
    chk(rdat, 32'h01100005, "countdown running");
    step(20);
    tap(IR_CTRL_B, 32'h0, 1'h0);
    chk(rdat, 32'h01100004, "countdown done");
    $display("test modes done");
    conclude();
  end
endmodule : tb_tcp_top
